/* verilog/sbl_load_unit.sv */
// Decode and execute unit for halfword register, unprivileged halfword and signed byte loads
`timescale 1ns/1ns
`default_nettype none

module sbl_load_unit (
  // Clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  sys_rst_in,
  // Instruction issue
  input  wire logic                  instr_valid_in,
  input  wire logic [31:0]           instr_in,
  input  wire logic                  instr_wide_in,
  input  wire logic [31:0]           instr_pc_in,
  output logic                       instr_ready_out,
  // Core configuration and flags
  input  wire logic                  main_ext_in,
  input  wire logic                  carry_flag_in,
  // Register file read
  output logic [3:0]                 base_idx_out,
  output logic [3:0]                 index_idx_out,
  input  wire logic [31:0]           base_data_in,
  input  wire logic [31:0]           index_data_in,
  // Stack limit lookup
  output logic                       sp_lookup_out,
  input  wire logic                  sp_limit_apply_in,
  input  wire logic [31:0]           sp_limit_in,
  // Load/store unit
  output logic                       mem_req_out,
  output logic [31:0]                mem_addr_out,
  output logic                       mem_size_half_out,
  output logic                       mem_unpriv_out,
  input  wire logic                  mem_ack_in,
  input  wire logic [15:0]           mem_rdata_in,
  input  wire logic                  mem_fault_in,
  input  wire logic [1:0]            mem_fault_kind_in,
  // Register file write
  output logic                       dest_wr_out,
  output logic [3:0]                 dest_idx_out,
  output logic [31:0]                dest_data_out,
  output logic                       base_wr_out,
  output logic [3:0]                 base_wr_idx_out,
  output logic [31:0]                base_wr_data_out,
  // Outcome
  output logic                       done_out,
  output logic                       undef_out,
  output logic                       unpredictable_out,
  output logic                       redirect_out,
  output sbl_pkg::sbl_redir_e        redirect_kind_out,
  output logic                       sp_fault_out,
  output logic                       mem_fault_out,
  output logic [1:0]                 mem_fault_kind_out
);
  import sbl_pkg::*;

  // Shifter shared by every register-offset form
  function automatic logic [31:0] shift_value(input logic [31:0] val, input logic [2:0] kind,
                                              input logic [4:0] amt, input logic carry);
    logic [63:0] rot;
    rot = {val, val} >> amt;
    case (kind)
      SBL_SH_LSL: shift_value = val << amt;
      SBL_SH_LSR: shift_value = val >> amt;
      SBL_SH_ASR: shift_value = $signed(val) >>> amt;
      SBL_SH_ROR: shift_value = rot[31:0];
      SBL_SH_RRX: shift_value = {carry, val[31:1]};
      default:    shift_value = val;
    endcase
  endfunction

  // Zero or sign extension of the returned data
  function automatic logic [31:0] extend_load(input logic [15:0] data, input logic half, input logic sgn);
    if (half) begin
      extend_load = {16'h0000, data};
    end else if (sgn) begin
      extend_load = {{24{data[7]}}, data[7:0]};
    end else begin
      extend_load = {24'h00_0000, data[7:0]};
    end
  endfunction

  // State and captured instruction
  sbl_state_e  state_reg;
  sbl_state_e  state_next;
  logic [31:0] instr_reg;
  logic        wide_reg;
  logic [31:0] pc_reg;

  // Memory phase context
  logic [31:0] addr_reg;
  logic        half_reg;
  logic        sign_reg;
  logic        unpriv_reg;
  logic        wback_reg;
  logic [31:0] wb_addr_reg;
  logic [3:0]  dest_reg;
  logic [3:0]  base_reg;

  // Field extraction
  wire [15:0] hw1         = instr_reg[31:16];
  wire [15:0] hw2         = instr_reg[15:0];
  wire [3:0]  dest_field  = wide_reg ? hw2[15:12] : {1'b0, hw2[2:0]};
  wire [3:0]  base_field  = wide_reg ? hw1[3:0] : {1'b0, hw2[5:3]};
  wire [3:0]  index_field = wide_reg ? hw2[3:0] : {1'b0, hw2[8:6]};
  wire [7:0]  short_offset_field = hw2[7:0];
  wire [11:0] long_offset_field  = hw2[11:0];
  wire [1:0]  shift_amount_field = hw2[5:4];
  wire        p_bit       = hw2[SBL_P_BIT];
  wire        u_bit       = hw2[SBL_U_BIT];
  wire        w_bit       = hw2[SBL_W_BIT];
  wire        lit_u_bit   = hw1[SBL_U_BIT_LIT];
  wire        dest_ones   = dest_field == SBL_REG_PC;
  wire        base_ones   = base_field == SBL_REG_PC;
  wire        dest_sp     = dest_field == SBL_REG_SP;
  wire        index_bad   = index_field == SBL_REG_SP || index_field == SBL_REG_PC;

  // Opcode matching
  wire m_n_half  = !wide_reg && hw2[15:9] == SBL_N_HALF_REG;
  wire m_n_sb    = !wide_reg && hw2[15:9] == SBL_N_SB_REG;
  wire m_h_grp   = wide_reg && hw1[15:4] == SBL_HW1_HALF_GRP;
  wire m_h_unpr  = m_h_grp && hw2[11:8] == SBL_HW2_UNPRIV;
  wire m_h_reg   = m_h_grp && hw2[11:6] == SBL_HW2_REG_PAD;
  wire m_lit     = wide_reg && hw1[15:8] == SBL_HW1_LIT_HI && hw1[6:0] == SBL_HW1_LIT_LO;
  wire m_sb_i12  = wide_reg && hw1[15:4] == SBL_HW1_SB_LONG_OFFSET_FIELD && !m_lit;
  wire m_sb_grp  = wide_reg && hw1[15:4] == SBL_HW1_SB_GRP && !m_lit;
  wire m_sb_i8   = m_sb_grp && hw2[SBL_SHORT_OFFSET_FIELD_SEL];
  wire m_sb_reg  = m_sb_grp && hw2[11:6] == SBL_HW2_REG_PAD;

  // Redirects to other instructions
  wire rd_half_lit = (m_h_unpr || m_h_reg) && base_ones;
  wire rd_pldw     = m_h_reg && !base_ones && dest_ones;
  wire rd_pli      = (m_sb_i12 || m_lit || m_sb_reg) && dest_ones
                   || m_sb_i8 && dest_ones && p_bit && !u_bit && !w_bit;
  wire rd_unpr_sb  = m_sb_i8 && !rd_pli && p_bit && u_bit && !w_bit;
  wire redirect    = rd_half_lit || rd_pldw || rd_pli || rd_unpr_sb;
  wire sbl_redir_e redir_kind = rd_half_lit ? SBL_RD_HALF_LITERAL :
                                rd_pldw     ? SBL_RD_DATA_PRELOADW :
                                rd_pli      ? SBL_RD_INSTR_PRELOAD :
                                rd_unpr_sb  ? SBL_RD_UNPRIV_SB : SBL_RD_NONE;

  // Executed form; base ones on signed byte forms lands on the literal form
  wire sbl_op_e op = m_n_half || m_h_reg ? SBL_OP_HALF_REG :
                     m_h_unpr            ? SBL_OP_HALF_UNPR :
                     m_sb_i12            ? SBL_OP_SB_LONG_OFFSET_FIELD :
                     m_sb_i8             ? SBL_OP_SB_SHORT_OFFSET_FIELD :
                     m_lit               ? SBL_OP_SB_LIT :
                     m_n_sb || m_sb_reg  ? SBL_OP_SB_REG : SBL_OP_NONE;

  // Addressing mode flags
  wire op_i8     = op == SBL_OP_SB_SHORT_OFFSET_FIELD;
  wire op_reg    = op == SBL_OP_HALF_REG || op == SBL_OP_SB_REG;
  wire idx_flag  = op_i8 ? p_bit : 1'b1;
  wire add_flag  = op_i8 ? u_bit : op == SBL_OP_SB_LIT ? lit_u_bit : 1'b1;
  wire wback     = op_i8 && w_bit;

  // Undefined and unpredictable encodings
  wire undef_enc = op == SBL_OP_NONE
                || wide_reg && !main_ext_in
                || op_i8 && !p_bit && !w_bit;
  wire unpred    = op == SBL_OP_HALF_UNPR && (dest_sp || dest_ones)
                || wide_reg && op_reg && (dest_sp || index_bad)
                || (op == SBL_OP_SB_LONG_OFFSET_FIELD || op == SBL_OP_SB_LIT) && dest_sp
                || op_i8 && (dest_sp || dest_ones && w_bit || wback && base_field == dest_field);

  // Offset and address formation
  wire [4:0]  sh_amt   = wide_reg ? {3'b000, shift_amount_field} : 5'h00;
  wire [31:0] reg_off  = shift_value(index_data_in, SBL_SH_LSL, sh_amt, carry_flag_in);
  wire [31:0] imm32    = op == SBL_OP_HALF_UNPR || op_i8 ? {24'h00_0000, short_offset_field}
                                                         : {20'h0_0000, long_offset_field};
  wire [31:0] offset   = op_reg ? reg_off : imm32;
  wire [31:0] base_val = op == SBL_OP_SB_LIT ? {pc_reg[31:2], 2'b00} : base_data_in;
  wire [31:0] off_addr = add_flag ? base_val + offset : base_val - offset;
  wire [31:0] address  = idx_flag ? off_addr : base_val;

  // Stack limit check, never on register forms since they never write back
  wire sp_wb       = base_field == SBL_REG_SP && wback && !op_reg;
  wire limit_apply = sp_wb && sp_limit_apply_in;
  wire limit_fail  = limit_apply && off_addr < sp_limit_in;

  // Sequencer decisions
  wire exec_now  = state_reg == SBL_ST_EXEC;
  wire mem_now   = state_reg == SBL_ST_MEM;
  wire exec_bad  = exec_now && (redirect || undef_enc || unpred);
  wire exec_stop = exec_bad || exec_now && limit_fail;
  wire exec_go   = exec_now && !exec_stop;
  wire mem_ok    = mem_now && mem_ack_in && !mem_fault_in;
  wire mem_bad   = mem_now && mem_ack_in && mem_fault_in;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SBL_ST_IDLE: if (instr_valid_in) state_next = SBL_ST_EXEC;
      SBL_ST_EXEC: state_next = exec_stop ? SBL_ST_IDLE : SBL_ST_MEM;
      SBL_ST_MEM:  if (mem_ack_in) state_next = SBL_ST_IDLE;
      default:     state_next = SBL_ST_IDLE;
    endcase
  end

  // Handshakes and read ports
  assign instr_ready_out = state_reg == SBL_ST_IDLE;
  assign base_idx_out    = base_field;
  assign index_idx_out   = index_field;
  assign sp_lookup_out   = exec_now && sp_wb;
  assign mem_req_out     = mem_now;
  assign mem_addr_out    = addr_reg;
  assign mem_size_half_out = half_reg;
  assign mem_unpriv_out  = unpriv_reg;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_reg <= SBL_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Instruction capture
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      instr_reg <= SBL_RST_WORD;
      wide_reg  <= 1'b0;
      pc_reg    <= SBL_RST_WORD;
    end else if (instr_ready_out && instr_valid_in) begin
      instr_reg <= instr_in;
      wide_reg  <= instr_wide_in;
      pc_reg    <= instr_pc_in;
    end
  end

  // Memory phase context, held stable while the request waits
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      addr_reg    <= SBL_RST_WORD;
      wb_addr_reg <= SBL_RST_WORD;
      half_reg    <= 1'b0;
      sign_reg    <= 1'b0;
      unpriv_reg  <= 1'b0;
      wback_reg   <= 1'b0;
      dest_reg    <= SBL_RST_IDX;
      base_reg    <= SBL_RST_IDX;
    end else if (exec_go) begin
      addr_reg    <= address;
      wb_addr_reg <= off_addr;
      half_reg    <= op == SBL_OP_HALF_REG || op == SBL_OP_HALF_UNPR;
      sign_reg    <= op != SBL_OP_HALF_REG && op != SBL_OP_HALF_UNPR;
      unpriv_reg  <= op == SBL_OP_HALF_UNPR;
      wback_reg   <= wback;
      dest_reg    <= dest_field;
      base_reg    <= base_field;
    end
  end

  // Register file writes, one-cycle pulses after the data returns
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      dest_wr_out      <= 1'b0;
      dest_idx_out     <= SBL_RST_IDX;
      dest_data_out    <= SBL_RST_WORD;
      base_wr_out      <= 1'b0;
      base_wr_idx_out  <= SBL_RST_IDX;
      base_wr_data_out <= SBL_RST_WORD;
    end else begin
      dest_wr_out      <= mem_ok;
      base_wr_out      <= mem_ok && wback_reg;
      if (mem_ok) begin
        dest_idx_out     <= dest_reg;
        dest_data_out    <= extend_load(mem_rdata_in, half_reg, sign_reg);
        base_wr_idx_out  <= base_reg;
        base_wr_data_out <= wb_addr_reg;
      end
    end
  end

  // Outcome pulses; a failed limit check skips both the load and the base update
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      done_out           <= 1'b0;
      undef_out          <= 1'b0;
      unpredictable_out  <= 1'b0;
      redirect_out       <= 1'b0;
      redirect_kind_out  <= SBL_RD_NONE;
      sp_fault_out       <= 1'b0;
      mem_fault_out      <= 1'b0;
      mem_fault_kind_out <= SBL_FK_USAGE;
    end else begin
      done_out           <= exec_stop || mem_now && mem_ack_in;
      redirect_out       <= exec_now && redirect;
      redirect_kind_out  <= exec_now ? redir_kind : SBL_RD_NONE;
      undef_out          <= exec_now && !redirect && (undef_enc || unpred);
      unpredictable_out  <= exec_now && !redirect && !undef_enc && unpred;
      sp_fault_out       <= exec_now && !exec_bad && limit_fail;
      mem_fault_out      <= mem_bad;
      if (mem_bad) begin
        mem_fault_kind_out <= mem_fault_kind_in;
      end
    end
  end

endmodule

`default_nettype wire

/* common/sbl_pkg.sv */
// Shared constants and types for the signed byte and unprivileged halfword load unit
package sbl_pkg;

  // Control states of the load sequencer
  typedef enum logic [1:0] {
    SBL_ST_IDLE = 2'b00,
    SBL_ST_EXEC = 2'b01,
    SBL_ST_MEM  = 2'b10
  } sbl_state_e;

  // Instruction forms executed here
  typedef enum logic [2:0] {
    SBL_OP_NONE      = 3'b000,
    SBL_OP_HALF_REG  = 3'b001,
    SBL_OP_HALF_UNPR = 3'b010,
    SBL_OP_SB_LONG_OFFSET_FIELD  = 3'b011,
    SBL_OP_SB_SHORT_OFFSET_FIELD   = 3'b100,
    SBL_OP_SB_LIT    = 3'b101,
    SBL_OP_SB_REG    = 3'b110
  } sbl_op_e;

  // Encodings handed on to another decoder
  typedef enum logic [2:0] {
    SBL_RD_NONE          = 3'b000,
    SBL_RD_HALF_LITERAL  = 3'b001,
    SBL_RD_DATA_PRELOADW = 3'b010,
    SBL_RD_INSTR_PRELOAD = 3'b011,
    SBL_RD_UNPRIV_SB     = 3'b100
  } sbl_redir_e;

  // Shift types for the index operand
  localparam logic [2:0] SBL_SH_LSL = 3'h0;
  localparam logic [2:0] SBL_SH_LSR = 3'h1;
  localparam logic [2:0] SBL_SH_ASR = 3'h2;
  localparam logic [2:0] SBL_SH_ROR = 3'h3;
  localparam logic [2:0] SBL_SH_RRX = 3'h4;

  // Memory fault kinds reported by the load/store unit
  localparam logic [1:0] SBL_FK_USAGE  = 2'h0;
  localparam logic [1:0] SBL_FK_BUS    = 2'h1;
  localparam logic [1:0] SBL_FK_MEMMAN = 2'h2;
  localparam logic [1:0] SBL_FK_SECURE = 2'h3;

  // Opcode patterns, upper and lower halfword of wide forms
  localparam logic [11:0] SBL_HW1_HALF_GRP = 12'hF83;
  localparam logic [11:0] SBL_HW1_SB_LONG_OFFSET_FIELD = 12'hF99;
  localparam logic [11:0] SBL_HW1_SB_GRP   = 12'hF91;
  localparam logic [7:0]  SBL_HW1_LIT_HI   = 8'hF9;
  localparam logic [6:0]  SBL_HW1_LIT_LO   = 7'h1F;
  localparam logic [3:0]  SBL_HW2_UNPRIV   = 4'hE;
  localparam logic [5:0]  SBL_HW2_REG_PAD  = 6'h00;
  // Narrow register-offset opcodes
  localparam logic [6:0]  SBL_N_HALF_REG   = 7'h2D;
  localparam logic [6:0]  SBL_N_SB_REG     = 7'h2B;

  // Special register numbers
  localparam logic [3:0]  SBL_REG_SP       = 4'hD;
  localparam logic [3:0]  SBL_REG_PC       = 4'hF;

  // Field positions in the upper and lower halfword
  localparam int SBL_U_BIT_LIT = 7;
  localparam int SBL_P_BIT     = 10;
  localparam int SBL_U_BIT     = 9;
  localparam int SBL_W_BIT     = 8;
  localparam int SBL_SHORT_OFFSET_FIELD_SEL  = 11;

  // Reset values
  localparam logic [31:0] SBL_RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  SBL_RST_IDX  = 4'h0;

endpackage

/* testbench/sbl_load_monitor.sv */
// Port-level checker for the load unit
`timescale 1ns/1ns
`default_nettype none
module sbl_load_monitor
  import sbl_pkg::*;
(
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  // Issue and lookup
  input wire logic        instr_valid_in,
  input wire logic        instr_ready_out,
  input wire logic [31:0] instr_in,
  input wire logic        instr_wide_in,
  input wire logic [3:0]  base_idx_out,
  input wire logic [3:0]  index_idx_out,
  input wire logic        sp_lookup_out,
  input wire logic        sp_limit_apply_in,
  // Memory side
  input wire logic        mem_req_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic        mem_size_half_out,
  input wire logic        mem_unpriv_out,
  input wire logic        mem_ack_in,
  input wire logic [15:0] mem_rdata_in,
  input wire logic        mem_fault_in,
  input wire logic [1:0]  mem_fault_kind_in,
  // Outcome
  input wire logic        dest_wr_out,
  input wire logic [31:0] dest_data_out,
  input wire logic        base_wr_out,
  input wire logic        done_out,
  input wire logic        undef_out,
  input wire logic        unpredictable_out,
  input wire logic        redirect_out,
  input wire logic        sp_fault_out,
  input wire logic        mem_fault_out,
  input wire logic [1:0]  mem_fault_kind_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_take;
    instr_valid_in && instr_ready_out;
  endsequence
  sequence s_ack_ok;
    mem_req_out && mem_ack_in && !mem_fault_in;
  endsequence
  sequence s_ack_bad;
    mem_req_out && mem_ack_in && mem_fault_in;
  endsequence
  one_at_time_a: assert property (s_take |=> !instr_ready_out)
    else $error("ready high while busy");
  done_bound_a: assert property (s_take |-> ##[2:40] done_out)
    else $error("instruction never finished");
  req_hold_a: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)
    && $stable(mem_unpriv_out) && $stable(mem_size_half_out))
    else $error("memory request changed before ack");
  ack_write_a: assert property (s_ack_ok |=> done_out && dest_wr_out)
    else $error("no destination write after ack");
  fault_stop_a: assert property (s_ack_bad |=> mem_fault_out && done_out && !dest_wr_out
    && mem_fault_kind_out == $past(mem_fault_kind_in))
    else $error("memory fault not reported");
  half_zext_a: assert property (dest_wr_out && $past(mem_size_half_out)
    |-> dest_data_out == {16'h0000, $past(mem_rdata_in)})
    else $error("halfword not zero extended");
  byte_sext_a: assert property (dest_wr_out && !$past(mem_size_half_out)
    |-> dest_data_out == {{24{$past(mem_rdata_in[7])}}, $past(mem_rdata_in[7:0])})
    else $error("byte not sign extended");
  unpriv_half_a: assert property (mem_req_out && mem_unpriv_out |-> mem_size_half_out)
    else $error("unprivileged access of wrong size");
  base_read_a: assert property (s_take |=> base_idx_out ==
    ($past(instr_wide_in) ? $past(instr_in[19:16]) : {1'b0, $past(instr_in[5:3])}))
    else $error("wrong base register read");
  index_read_a: assert property (s_take |=> index_idx_out ==
    ($past(instr_wide_in) ? $past(instr_in[3:0]) : {1'b0, $past(instr_in[8:6])}))
    else $error("wrong index register read");
  lookup_sp_a: assert property (sp_lookup_out |-> base_idx_out == SBL_REG_SP)
    else $error("limit lookup for non stack base");
  limit_fail_a: assert property (sp_fault_out |-> done_out && !dest_wr_out && !base_wr_out
    && $past(sp_lookup_out && sp_limit_apply_in) && !$past(mem_req_out))
    else $error("limit fault without lookup");
  wback_ok_a: assert property (base_wr_out |-> done_out && !sp_fault_out && !mem_fault_out)
    else $error("base written on failed load");
  unpred_undef_a: assert property (unpredictable_out |-> undef_out && done_out && !dest_wr_out)
    else $error("unpredictable not handled as undefined");
  early_stop_a: assert property (redirect_out || undef_out |-> done_out
    && $past(instr_valid_in && instr_ready_out, 2) && !$past(mem_req_out))
    else $error("decode stop late or after memory access");
endmodule
bind sbl_load_unit sbl_load_monitor u_sbl_load_monitor (.*);
`default_nettype wire

/* testbench/sbl_mem_model.sv */
// Load/store unit model answering the unit's memory requests
`timescale 1ns/1ns
`default_nettype none
module sbl_mem_model (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // Request side
  input  wire logic        mem_req_in,
  input  wire logic [31:0] mem_addr_in,
  // Test controls
  input  wire logic [1:0]  delay_in,
  input  wire logic        fault_en_in,
  input  wire logic [1:0]  fault_kind_in,
  // Answer side
  output logic             mem_ack_out,
  output logic [15:0]      mem_rdata_out,
  output logic             mem_fault_out,
  output logic [1:0]       mem_fault_kind_out
);
  logic [1:0]  wait_reg;
  logic [15:0] last_reg;
  logic [15:0] data_w;
  // Address-tied pattern so a wrong lane or address shows
  assign data_w = {~mem_addr_in[7:0], mem_addr_in[7:0] ^ 8'h5A};
  // Stale data inverted between answers so it never matches by luck
  assign mem_rdata_out = mem_ack_out ? data_w : ~last_reg;
  assign mem_fault_out = mem_ack_out & fault_en_in;
  assign mem_fault_kind_out = mem_ack_out ? fault_kind_in : ~fault_kind_in;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in | mem_ack_out | !mem_req_in) begin
      mem_ack_out <= 1'b0;
      wait_reg <= 2'h0;
    end else if (wait_reg == delay_in) begin
      mem_ack_out <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
    if (sys_rst_in) begin
      last_reg <= 16'h0000;
    end else if (mem_ack_out) begin
      last_reg <= data_w;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the load unit
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sbl_pkg::*;
  logic         clock_in, sys_rst_in, instr_valid_in, instr_wide_in, instr_ready_out;
  logic         main_ext_in, carry_flag_in, sp_lookup_out, sp_limit_apply_in, mem_req_out;
  logic         mem_size_half_out, mem_unpriv_out, mem_ack_in, mem_fault_in, dest_wr_out;
  logic         base_wr_out, done_out, undef_out, unpredictable_out, redirect_out;
  logic         sp_fault_out, mem_fault_out, fault_en;
  logic [1:0]   mem_fault_kind_in, mem_fault_kind_out, delay, fault_kind;
  logic [3:0]   base_idx_out, index_idx_out, dest_idx_out, base_wr_idx_out;
  logic [15:0]  mem_rdata_in;
  logic [31:0]  instr_in, instr_pc_in, base_data_in, index_data_in, sp_limit_in;
  logic [31:0]  mem_addr_out, dest_data_out, base_wr_data_out;
  logic [114:0] g;
  sbl_redir_e   redirect_kind_out;
  int           n_mismatch, checks_done;

  sbl_load_unit u_sbl_load_unit (.*);
  sbl_mem_model u_sbl_mem_model (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .mem_req_in(mem_req_out),
    .mem_addr_in(mem_addr_out), .delay_in(delay), .fault_en_in(fault_en), .fault_kind_in(fault_kind),
    .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in), .mem_fault_out(mem_fault_in),
    .mem_fault_kind_out(mem_fault_kind_in));

  function automatic logic [31:0] sx(input logic [31:0] a);
    logic [7:0] b;
    b = a[7:0] ^ 8'h5A;
    return {{24{b[7]}}, b};
  endfunction
  function automatic logic [31:0] zx(input logic [31:0] a);
    return {16'h0000, ~a[7:0], a[7:0] ^ 8'h5A};
  endfunction
  // Outcome fields, masked by their strobes so idle values never count
  function automatic logic [114:0] snap();
    return {undef_out, unpredictable_out, redirect_out, sp_fault_out, mem_fault_out,
      redirect_kind_out & {3{redirect_out}}, mem_req_out, mem_size_half_out & mem_req_out,
      mem_unpriv_out & mem_req_out, mem_addr_out & {32{mem_req_out}}, dest_wr_out,
      dest_idx_out & {4{dest_wr_out}}, dest_data_out & {32{dest_wr_out}}, base_wr_out,
      base_wr_data_out & {32{base_wr_out}}, mem_fault_kind_out & {2{mem_fault_out}}};
  endfunction
  task automatic chk(input logic [114:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic run(input logic [31:0] ins, input logic w, input logic [31:0] b, x);
    int n;
    while (instr_ready_out !== 1'b1) @(negedge clock_in);
    instr_in = ins;
    instr_wide_in = w;
    base_data_in = b;
    index_data_in = x;
    instr_valid_in = 1'b1;
    g = '0;
    n = 0;
    @(negedge clock_in);
    instr_valid_in = 1'b0;
    while (done_out !== 1'b1 && n < 30) begin
      g = g | snap();
      n++;
      @(negedge clock_in);
    end
    g = g | snap();
    if (n == 30) begin
      n_mismatch++;
      $display("MISMATCH t=%0t done=%h exp=%h", $time, done_out, 1'b1);
    end
  endtask
  task automatic ld(input logic [31:0] a, input logic h, u, input logic [3:0] t,
                    input logic [31:0] d, input logic bw, input logic [31:0] bd);
    chk({8'h00, 1'b1, h, u, a, 1'b1, t, d, bw, bd & {32{bw}}, 2'h0});
  endtask
  task automatic stop(input logic [4:0] f, input logic [2:0] k);
    chk({f, k, 107'h0});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // Whole sequence needs well under two hundred cycles
  initial begin
    repeat (3000) @(posedge clock_in);
    n_mismatch++;
    results();
  end
  initial begin
    logic [2:0]  p;
    logic [31:0] off, a;
    {sys_rst_in, main_ext_in, sp_limit_apply_in, fault_en} = 4'hC;
    {instr_valid_in, instr_wide_in, carry_flag_in, delay, fault_kind} = 7'h00;
    {instr_in, instr_pc_in, base_data_in, index_data_in, sp_limit_in} = '0;
    repeat (8) @(negedge clock_in);
    sys_rst_in = 1'b0;
    run(32'h0000_5A8B, 1'b0, 32'h1000_0010, 32'h22);
    ld(32'h1000_0032, 1'b1, 1'b0, 4'h3, zx(32'h1000_0032), 1'b0, 32'h0);
    carry_flag_in = 1'b1;
    run(32'hF834_5036, 1'b1, 32'h1000_0000, 32'h11);
    ld(32'h1000_0088, 1'b1, 1'b0, 4'h5, zx(32'h1000_0088), 1'b0, 32'h0);
    run(32'hF834_F036, 1'b1, 32'h1000_0000, 32'h11);
    stop(5'b00100, 3'h2);
    delay = 2'h3;
    run(32'hF831_2EFF, 1'b1, 32'h1000_0040, 32'h0);
    ld(32'h1000_013F, 1'b1, 1'b1, 4'h2, zx(32'h1000_013F), 1'b0, 32'h0);
    run(32'hF831_DE10, 1'b1, 32'h1000_0040, 32'h0);
    stop(5'b11000, 3'h0);
    run(32'hF831_FE10, 1'b1, 32'h1000_0040, 32'h0);
    stop(5'b11000, 3'h0);
    main_ext_in = 1'b0;
    run(32'hF83F_2E10, 1'b1, 32'h1000_0040, 32'h0);
    stop(5'b00100, 3'h1);
    run(32'hF831_2E10, 1'b1, 32'h1000_0040, 32'h0);
    stop(5'b10000, 3'h0);
    main_ext_in = 1'b1;
    fault_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      fault_kind = k[1:0];
      run(32'hF831_2E04, 1'b1, 32'h1000_0040, 32'h0);
      chk({8'h08, 3'b111, 32'h1000_0044, 70'h0, k[1:0]});
    end
    fault_en = 1'b0;
    delay = 2'h0;
    run(32'hF993_4FFF, 1'b1, 32'h1000_0001, 32'h0);
    ld(32'h1000_1000, 1'b0, 1'b0, 4'h4, sx(32'h1000_1000), 1'b0, 32'h0);
    run(32'hF993_DFFF, 1'b1, 32'h1000_0001, 32'h0);
    stop(5'b11000, 3'h0);
    for (int i = 0; i < 8; i++) begin
      p = i[2:0];
      off = p[1] ? 32'h1000_00F0 : 32'h1000_0090;
      a = p[2] ? off : 32'h1000_00C0;
      run({16'hF912, 4'h3, 1'b1, p, 8'h30}, 1'b1, 32'h1000_00C0, 32'h0);
      if (p == 3'h0 || p == 3'h2) stop(5'b10000, 3'h0);
      else if (p == 3'h6) stop(5'b00100, 3'h4);
      else ld(a, 1'b0, 1'b0, 4'h3, sx(a), p[0], off);
    end
    run(32'hF912_FC30, 1'b1, 32'h1000_00C0, 32'h0);
    stop(5'b00100, 3'h3);
    instr_pc_in = 32'h2000_0006;
    run(32'hF99F_6123, 1'b1, 32'h0, 32'h0);
    ld(32'h2000_0127, 1'b0, 1'b0, 4'h6, sx(32'h2000_0127), 1'b0, 32'h0);
    run(32'hF91F_6FFF, 1'b1, 32'h0, 32'h0);
    ld(32'h1FFF_F005, 1'b0, 1'b0, 4'h6, sx(32'h1FFF_F005), 1'b0, 32'h0);
    run(32'hF99F_F123, 1'b1, 32'h0, 32'h0);
    stop(5'b00100, 3'h3);
    run(32'hF99F_D123, 1'b1, 32'h0, 32'h0);
    stop(5'b11000, 3'h0);
    sp_limit_apply_in = 1'b1;
    sp_limit_in = 32'h2000_00F0;
    run(32'hF91D_3D10, 1'b1, 32'h2000_0100, 32'h0);
    ld(32'h2000_00F0, 1'b0, 1'b0, 4'h3, sx(32'h2000_00F0), 1'b1, 32'h2000_00F0);
    g = {111'h0, base_wr_idx_out};
    chk({111'h0, SBL_REG_SP});
    sp_limit_in = 32'h2000_00F4;
    run(32'hF91D_3D10, 1'b1, 32'h2000_0100, 32'h0);
    stop(5'b00010, 3'h0);
    sp_limit_in = 32'hFFFF_FFFF;
    run(32'hF91D_5026, 1'b1, 32'h2000_0000, 32'h3);
    ld(32'h2000_000C, 1'b0, 1'b0, 4'h5, sx(32'h2000_000C), 1'b0, 32'h0);
    sp_limit_apply_in = 1'b0;
    run(32'hF914_502D, 1'b1, 32'h2000_0000, 32'h3);
    stop(5'b11000, 3'h0);
    run(32'hF914_F026, 1'b1, 32'h2000_0000, 32'h3);
    stop(5'b00100, 3'h3);
    run(32'h0000_57E9, 1'b0, 32'h1000_0080, 32'h7);
    ld(32'h1000_0087, 1'b0, 1'b0, 4'h1, sx(32'h1000_0087), 1'b0, 32'h0);
    results();
  end
endmodule
`default_nettype wire
